/* File: shared/acpc_map.vh */
// Register map, field layout and codes for the ADC program control registers
// Operation
// - Clock divider field divides input clock by value plus one (1 to 8).
// - Four-bit test field selects one of twelve output test patterns or off.
// - Outside digital reset mode, any nonzero test selection puts test words on data outputs instead of samples.
// - Self-test register bit 0 starts self-test; bit 2 is the init control.
`ifndef ACPC_MAP_VH
`define ACPC_MAP_VH

// Register addresses on the serial control port
`define ACPC_ADDR_MODES   13'h008
`define ACPC_ADDR_CLKDIV  13'h00b
`define ACPC_ADDR_TEST    13'h00d
`define ACPC_ADDR_BIST    13'h00e
`define ACPC_ADDR_OFFSET  13'h010

// Writable bits per register
`define ACPC_MASK_MODES   8'he3
`define ACPC_MASK_CLKDIV  8'h07
`define ACPC_MASK_TEST    8'hff
`define ACPC_MASK_BIST    8'h05
`define ACPC_MASK_OFFSET  8'hff
`define ACPC_RST_VAL      8'h00

// Field positions
`define ACPC_MODE_MSB        1
`define ACPC_MODE_LSB        0
`define ACPC_DIV_MSB         2
`define ACPC_DIV_LSB         0
`define ACPC_TSEL_MSB        3
`define ACPC_TSEL_LSB        0
`define ACPC_PN_SHORT_RST    4
`define ACPC_PN_LONG_RST     5
`define ACPC_BIST_START_BIT  0
`define ACPC_SELF_TEST_INIT_BIT   2

// Operating mode codes
`define ACPC_MODE_RUN   2'h0
`define ACPC_MODE_PDWN  2'h1
`define ACPC_MODE_STBY  2'h2
`define ACPC_MODE_DRST  2'h3

// Output test selections
`define ACPC_T_OFF      4'h0
`define ACPC_T_MID      4'h1
`define ACPC_T_POSFS    4'h2
`define ACPC_T_NEGFS    4'h3
`define ACPC_T_CHECKER  4'h4
`define ACPC_T_PNLONG   4'h5
`define ACPC_T_PNSHORT  4'h6
`define ACPC_T_WTOGGLE  4'h7
`define ACPC_T_USER     4'h8
`define ACPC_T_BTOGGLE  4'h9
`define ACPC_T_SYNC     4'ha
`define ACPC_T_ONEHIGH  4'hb
`define ACPC_T_MIXED    4'hc

// Pattern words
`define ACPC_W_MID      12'h800
`define ACPC_W_POSFS    12'hfff
`define ACPC_W_NEGFS    12'h000
`define ACPC_W_CHK_A    12'haaa
`define ACPC_W_CHK_B    12'h555
`define ACPC_W_SYNC     12'h03f
`define ACPC_W_ONEHIGH  12'h800
`define ACPC_W_MIXED    12'ha0f
`define ACPC_PN_SEED_L  23'h7fffff
`define ACPC_PN_SEED_S  9'h1ff

// Serial instruction layout
`define ACPC_INSTR_LAST  4'hf
`define ACPC_BYTE_LAST   4'h7
`define ACPC_W_STREAM    2'h3

`endif

/* File: design/acpc_pattern.v */
// Output test pattern generator
`timescale 1ns/1ps
`include "acpc_map.vh"
module acpc_pattern #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst,
  input  wire             ce,
  // Control
  input  wire             advance,
  input  wire             hold,
  input  wire [3:0]       sel,
  input  wire             pn_long_rst,
  input  wire             pn_short_rst,
  input  wire [WIDTH-1:0] user_pattern,
  // Pattern out
  output reg  [WIDTH-1:0] word
);
  reg  [22:0] long_pseudorandom_pattern;
  reg  [8:0]  short_pseudorandom_pattern;
  reg         phase;
  wire [22:0] next_long;
  wire [8:0]  next_short;

  // x^23 + x^18 + 1 and x^9 + x^5 + 1
  assign next_long  = {long_pseudorandom_pattern[21:0],
                       long_pseudorandom_pattern[22] ^ long_pseudorandom_pattern[17]};
  assign next_short = {short_pseudorandom_pattern[7:0],
                       short_pseudorandom_pattern[8] ^ short_pseudorandom_pattern[4]};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      long_pseudorandom_pattern  <= `ACPC_PN_SEED_L;
      short_pseudorandom_pattern <= `ACPC_PN_SEED_S;
      phase                      <= 1'b0;
    end else if (ce) begin
      // Sequence reset bits hold the generators at their seed until cleared
      if (hold || pn_long_rst)
        long_pseudorandom_pattern <= `ACPC_PN_SEED_L;
      else if (advance)
        long_pseudorandom_pattern <= next_long;
      if (hold || pn_short_rst)
        short_pseudorandom_pattern <= `ACPC_PN_SEED_S;
      else if (advance)
        short_pseudorandom_pattern <= next_short;
      if (hold)
        phase <= 1'b0;
      else if (advance)
        phase <= ~phase;
    end
  end

  always @* begin
    case (sel)
      `ACPC_T_MID:     word = `ACPC_W_MID;
      `ACPC_T_POSFS:   word = `ACPC_W_POSFS;
      `ACPC_T_NEGFS:   word = `ACPC_W_NEGFS;
      `ACPC_T_CHECKER: word = phase ? `ACPC_W_CHK_B : `ACPC_W_CHK_A;
      `ACPC_T_PNLONG:  word = long_pseudorandom_pattern[WIDTH-1:0];
      `ACPC_T_PNSHORT: word = {{(WIDTH-9){1'b0}}, short_pseudorandom_pattern};
      `ACPC_T_WTOGGLE: word = phase ? `ACPC_W_NEGFS : `ACPC_W_POSFS;
      `ACPC_T_USER:    word = user_pattern;
      `ACPC_T_BTOGGLE: word = `ACPC_W_CHK_A;
      `ACPC_T_SYNC:    word = `ACPC_W_SYNC;
      `ACPC_T_ONEHIGH: word = `ACPC_W_ONEHIGH;
      `ACPC_T_MIXED:   word = `ACPC_W_MIXED;
      default:         word = {WIDTH{1'b0}};
    endcase
  end
endmodule // acpc_pattern

/* File: design/acpc_regs.v */
// Program control registers behind the serial control port, with mode, divider and test output
`timescale 1ns/1ps
`include "acpc_map.vh"
module acpc_regs #(
  parameter WIDTH = 12
) (
  // Clock, reset, enable
  input  wire             mclk,
  input  wire             rst,
  input  wire             ce,
  // Serial control port pins
  input  wire             spi_sclk,
  input  wire             spi_cs_n,
  input  wire             spi_sdio_in,
  output reg              spi_sdio_out,
  output reg              spi_sdio_oe,
  // Converter side
  input  wire [WIDTH-1:0] adc_sample,
  input  wire [WIDTH-1:0] user_pattern,
  output reg  [WIDTH-1:0] data_out,
  output reg              sample_strobe,
  // Mode and trim outputs
  output reg              power_down,
  output reg              standby,
  output reg              digital_reset,
  output reg  [2:0]       clk_div_ratio,
  output reg  [7:0]       offset_trim,
  output reg              self_test_start,
  output reg              self_test_init
);
  localparam ST_INSTR = 2'h0;
  localparam ST_DATA  = 2'h1;
  localparam ST_DONE  = 2'h2;

  // Registers
  reg  [7:0]       operating_modes;
  reg  [7:0]       clock_divide_ratio;
  reg  [7:0]       output_test_select;
  reg  [7:0]       self_test_control;
  reg  [7:0]       offset_adjust_q;

  // Pin synchronisers
  reg              sclk_s1, sclk_s2, sclk_d;
  reg              cs_s1, cs_s2;
  reg              sdi_s1, sdi_s2;

  // Serial engine
  reg  [1:0]       state;
  reg  [3:0]       bit_cnt;
  reg  [14:0]      instr;
  reg  [6:0]       dbyte;
  reg              rd;
  reg  [1:0]       left;
  reg  [12:0]      addr;
  reg  [7:0]       tx;
  reg              wr_stb;
  reg  [12:0]      wr_addr;
  reg  [7:0]       wr_data;

  reg  [2:0]       div_cnt;
  wire             rise;
  wire             fall;
  wire [12:0]      addr_dec;
  wire [12:0]      instr_addr;
  wire [WIDTH-1:0] pat_word;
  wire             test_on;
  wire             dp_hold;

  assign rise       = sclk_s2 & ~sclk_d;
  assign fall       = ~sclk_s2 & sclk_d;
  assign addr_dec   = addr - 13'h0001;
  assign instr_addr = {instr[11:0], sdi_s2};
  assign test_on    = output_test_select[`ACPC_TSEL_MSB:`ACPC_TSEL_LSB] != `ACPC_T_OFF;
  assign dp_hold    = operating_modes[`ACPC_MODE_MSB:`ACPC_MODE_LSB] != `ACPC_MODE_RUN;

  // Unmapped addresses read as zero
  function [7:0] rd_mux;
    input [12:0] a;
    begin
      case (a)
        `ACPC_ADDR_MODES:  rd_mux = operating_modes;
        `ACPC_ADDR_CLKDIV: rd_mux = clock_divide_ratio;
        `ACPC_ADDR_TEST:   rd_mux = output_test_select;
        `ACPC_ADDR_BIST:   rd_mux = self_test_control;
        `ACPC_ADDR_OFFSET: rd_mux = offset_adjust_q;
        default:           rd_mux = 8'h00;
      endcase
    end
  endfunction

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
    end else if (ce) begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      cs_s1   <= spi_cs_n;
      cs_s2   <= cs_s1;
      sdi_s1  <= spi_sdio_in;
      sdi_s2  <= sdi_s1;
    end
  end

  // Input sampled on rising clock, read data driven on falling clock
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state        <= ST_INSTR;
      bit_cnt      <= 4'h0;
      instr        <= 15'h0000;
      dbyte        <= 7'h00;
      rd           <= 1'b0;
      left         <= 2'h0;
      addr         <= 13'h0000;
      tx           <= 8'h00;
      wr_stb       <= 1'b0;
      wr_addr      <= 13'h0000;
      wr_data      <= 8'h00;
      spi_sdio_out <= 1'b0;
      spi_sdio_oe  <= 1'b0;
    end else if (ce) begin
      wr_stb <= 1'b0;
      if (cs_s2) begin
        state       <= ST_INSTR;
        bit_cnt     <= 4'h0;
        spi_sdio_oe <= 1'b0;
      end else if (rise) begin
        case (state)
          ST_INSTR: begin
            instr   <= {instr[13:0], sdi_s2};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `ACPC_INSTR_LAST) begin
              rd      <= instr[14];
              left    <= instr[13:12];
              addr    <= instr_addr;
              tx      <= rd_mux(instr_addr);
              bit_cnt <= 4'h0;
              state   <= ST_DATA;
            end
          end
          ST_DATA: begin
            dbyte   <= {dbyte[5:0], sdi_s2};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `ACPC_BYTE_LAST) begin
              bit_cnt <= 4'h0;
              wr_stb  <= ~rd;
              wr_addr <= addr;
              wr_data <= {dbyte, sdi_s2};
              // Multi-byte transfers walk down the address space
              addr    <= addr_dec;
              tx      <= rd_mux(addr_dec);
              if (left == 2'h0)
                state <= ST_DONE;
              else if (left != `ACPC_W_STREAM)
                left <= left - 2'h1;
            end
          end
          ST_DONE: begin
            bit_cnt <= 4'h0;
          end
          default: begin
            state <= ST_INSTR;
          end
        endcase
      end else if (fall) begin
        if (state == ST_DATA && rd) begin
          spi_sdio_oe  <= 1'b1;
          spi_sdio_out <= tx[7];
          tx           <= {tx[6:0], 1'b0};
        end else begin
          spi_sdio_oe <= 1'b0;
        end
      end
    end
  end

  // Writes take effect at once; masks keep unused bits at zero
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      operating_modes    <= `ACPC_RST_VAL;
      clock_divide_ratio <= `ACPC_RST_VAL;
      output_test_select <= `ACPC_RST_VAL;
      self_test_control  <= `ACPC_RST_VAL;
      offset_adjust_q    <= `ACPC_RST_VAL;
    end else if (ce && wr_stb) begin
      case (wr_addr)
        `ACPC_ADDR_MODES:  operating_modes    <= wr_data & `ACPC_MASK_MODES;
        `ACPC_ADDR_CLKDIV: clock_divide_ratio <= wr_data & `ACPC_MASK_CLKDIV;
        `ACPC_ADDR_TEST:   output_test_select <= wr_data & `ACPC_MASK_TEST;
        `ACPC_ADDR_BIST:   self_test_control  <= wr_data & `ACPC_MASK_BIST;
        `ACPC_ADDR_OFFSET: offset_adjust_q    <= wr_data & `ACPC_MASK_OFFSET;
        default:           offset_adjust_q    <= offset_adjust_q;
      endcase
    end
  end

  // Divider stays parked outside run mode so restart is phase-aligned
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt       <= 3'h0;
      sample_strobe <= 1'b0;
    end else if (ce) begin
      if (dp_hold) begin
        div_cnt       <= 3'h0;
        sample_strobe <= 1'b0;
      end else if (div_cnt >= clock_divide_ratio[`ACPC_DIV_MSB:`ACPC_DIV_LSB]) begin
        div_cnt       <= 3'h0;
        sample_strobe <= 1'b1;
      end else begin
        div_cnt       <= div_cnt + 3'h1;
        sample_strobe <= 1'b0;
      end
    end
  end

  acpc_pattern #(
    .WIDTH (WIDTH)
  ) u_pattern (
    .mclk         (mclk),
    .rst          (rst),
    .ce           (ce),
    .advance      (sample_strobe),
    .hold         (digital_reset),
    .sel          (output_test_select[`ACPC_TSEL_MSB:`ACPC_TSEL_LSB]),
    .pn_long_rst  (output_test_select[`ACPC_PN_LONG_RST]),
    .pn_short_rst (output_test_select[`ACPC_PN_SHORT_RST]),
    .user_pattern (user_pattern),
    .word         (pat_word)
  );

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_out        <= {WIDTH{1'b0}};
      power_down      <= 1'b0;
      standby         <= 1'b0;
      digital_reset   <= 1'b0;
      clk_div_ratio   <= 3'h0;
      offset_trim     <= 8'h00;
      self_test_start <= 1'b0;
      self_test_init  <= 1'b0;
    end else if (ce) begin
      power_down    <= operating_modes[`ACPC_MODE_MSB:`ACPC_MODE_LSB] == `ACPC_MODE_PDWN;
      standby       <= operating_modes[`ACPC_MODE_MSB:`ACPC_MODE_LSB] == `ACPC_MODE_STBY;
      digital_reset <= operating_modes[`ACPC_MODE_MSB:`ACPC_MODE_LSB] == `ACPC_MODE_DRST;
      clk_div_ratio   <= clock_divide_ratio[`ACPC_DIV_MSB:`ACPC_DIV_LSB];
      offset_trim     <= offset_adjust_q;
      self_test_start <= self_test_control[`ACPC_BIST_START_BIT];
      self_test_init  <= self_test_control[`ACPC_SELF_TEST_INIT_BIT];
      // Decoded from the field so the zeroed output lines up with the mode output
      if (operating_modes[`ACPC_MODE_MSB:`ACPC_MODE_LSB] == `ACPC_MODE_DRST)
        data_out <= {WIDTH{1'b0}};
      else if (test_on)
        data_out <= pat_word;
      else
        data_out <= adc_sample;
    end
  end
endmodule // acpc_regs

/* File: tb/acpc_regs_asserts.sv */
// Concurrent checks on the program control register outputs
`timescale 1ns/1ps
module acpc_regs_asserts #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input wire             mclk,
  input wire             rst,
  // Observed outputs
  input wire [WIDTH-1:0] data_out,
  input wire             sample_strobe,
  input wire             power_down,
  input wire             standby,
  input wire             digital_reset,
  input wire [2:0]       clk_div_ratio,
  input wire [7:0]       offset_trim,
  input wire             self_test_start,
  input wire             self_test_init
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire run_mode = !power_down && !standby && !digital_reset;

  a_mode_exclusive: assert property ($onehot0({power_down, standby, digital_reset}))
    else $error("more than one mode output high");
  a_idle_no_strobe: assert property (!run_mode |-> !sample_strobe)
    else $error("sample strobe outside run mode");
  a_drst_zero_out: assert property (digital_reset |-> data_out == {WIDTH{1'b0}})
    else $error("data output not zero in digital reset");
  a_div_one_rate: assert property (
    (run_mode && clk_div_ratio == 3'h0) [*3] |-> sample_strobe)
    else $error("strobe missing at divide by one");
  a_div_two_gap: assert property (
    sample_strobe && clk_div_ratio == 3'h1 |=> !sample_strobe)
    else $error("strobes adjacent at divide by two");
  a_reset_clear: assert property ($fell(rst) |-> data_out == {WIDTH{1'b0}} && !power_down
    && !standby && !digital_reset && clk_div_ratio == 3'h0 && offset_trim == 8'h00
    && !self_test_start && !self_test_init)
    else $error("outputs not zero after reset");
endmodule // acpc_regs_asserts

/* File: tb/acpc_host_model.sv */
// Host controller model driving the three-wire serial control port
`timescale 1ns/1ps
module acpc_host_model (
  // Clock
  input  wire mclk,
  // Serial control port
  output reg  spi_sclk,
  output reg  spi_cs_n,
  output wire spi_sdio_in,
  input  wire spi_sdio_out,
  input  wire spi_sdio_oe
);
  reg host_bit;
  // Released line has no pull, so the host side shows a toggling level
  assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : host_bit;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    host_bit = 1'b0;
  end
  task automatic tick(input integer n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic access(input rd, input [1:0] w, input [12:0] addr, input [15:0] wdata,
                        input integer nbits, output [15:0] rdata);
    reg [15:0] instr;
    integer i;
    begin
      instr = {rd, w, addr};
      rdata = 16'h0000;
      tick(1);
      spi_cs_n = 1'b0;
      for (i = 15 + nbits; i >= 0; i = i - 1) begin
        spi_sclk = 1'b0;
        host_bit = (i >= nbits) ? instr[i - nbits] : (rd ? ~host_bit : wdata[i]);
        tick(4);
        spi_sclk = 1'b1;
        rdata = {rdata[14:0], spi_sdio_in};
        tick(4);
      end
      spi_sclk = 1'b0;
      tick(4);
      spi_cs_n = 1'b1;
      tick(4);
    end
  endtask
endmodule // acpc_host_model

/* File: tb/test_acpc_regs.sv */
// Self-checking bench for the program control registers
`timescale 1ns/1ps
module test_acpc_regs;
  localparam WIDTH = 12;
  reg              mclk, rst, ce;
  reg  [WIDTH-1:0] adc_sample, user_pattern, w0, w1;
  wire             spi_sclk, spi_cs_n, spi_sdio_in, spi_sdio_out, spi_sdio_oe;
  wire [WIDTH-1:0] data_out;
  wire             sample_strobe, power_down, standby, digital_reset;
  wire             self_test_start, self_test_init;
  wire [2:0]       clk_div_ratio;
  wire [7:0]       offset_trim;
  integer          n_mismatch, comparisons, cycles, i, n, d;
  reg  [15:0]      q;
  reg  [12:0]      addrs [0:4];
  reg  [7:0]       masks [0:4];
  reg  [7:0]       codes [0:10];
  reg  [11:0]      words [0:10];

  acpc_regs #(.WIDTH(WIDTH)) i_acpc_regs (
    .mclk(mclk), .rst(rst), .ce(ce), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .adc_sample(adc_sample), .user_pattern(user_pattern), .data_out(data_out),
    .sample_strobe(sample_strobe), .power_down(power_down), .standby(standby),
    .digital_reset(digital_reset), .clk_div_ratio(clk_div_ratio),
    .offset_trim(offset_trim), .self_test_start(self_test_start),
    .self_test_init(self_test_init));
  acpc_host_model i_acpc_host_model (
    .mclk(mclk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdio_in(spi_sdio_in),
    .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe));

  always #12.5 mclk = ~mclk;

  task tally_and_finish;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input string what, input [15:0] exp, input [15:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        $display("ERROR %s expected %h seen %h", what, exp, got);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task wr(input [12:0] a, input [7:0] v);
    i_acpc_host_model.access(1'b0, 2'b00, a, {8'h00, v}, 8, q);
  endtask
  task rd_chk(input [12:0] a, input [7:0] exp);
    begin
      i_acpc_host_model.access(1'b1, 2'b00, a, 16'h0000, 8, q);
      check("register read", {8'h00, exp}, {8'h00, q[7:0]});
    end
  endtask

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end

  initial begin
    mclk = 1'b0; rst = 1'b1; ce = 1'b1; cycles = 0; n_mismatch = 0; comparisons = 0;
    adc_sample = 12'h123; user_pattern = 12'h5a6;
    addrs[0] = 13'h008; addrs[1] = 13'h00b; addrs[2] = 13'h00d; addrs[3] = 13'h00e;
    addrs[4] = 13'h010;
    masks[0] = 8'he3; masks[1] = 8'h07; masks[2] = 8'hff; masks[3] = 8'h05; masks[4] = 8'hff;
    codes[0] = 8'h00; codes[1] = 8'h01; codes[2] = 8'h02; codes[3] = 8'h03; codes[4] = 8'h08;
    codes[5] = 8'h09; codes[6] = 8'h0a; codes[7] = 8'h0b; codes[8] = 8'h0c; codes[9] = 8'h16;
    codes[10] = 8'h25;
    words[0] = 12'h123; words[1] = 12'h800; words[2] = 12'hfff; words[3] = 12'h000;
    words[4] = 12'h5a6; words[5] = 12'haaa; words[6] = 12'h03f; words[7] = 12'h800;
    words[8] = 12'ha0f; words[9] = 12'h1ff; words[10] = 12'hfff;
    repeat (5) @(posedge mclk);
    #2 rst = 1'b0;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 5; i = i + 1) begin
      rd_chk(addrs[i], 8'h00);
      wr(addrs[i], 8'hff);
      rd_chk(addrs[i], masks[i]);
      wr(addrs[i], 8'h00);
    end
    wr(13'h009, 8'hff);
    rd_chk(13'h009, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(13'h008, i[7:0]);
      check("mode outputs", {13'h0, i == 1, i == 2, i == 3},
            {13'h0, power_down, standby, digital_reset});
    end
    wr(13'h008, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      d = (i == 2) ? 3 : i;
      wr(13'h00b, d[7:0]);
      n = 0;
      repeat (24) begin
        @(posedge mclk);
        #2 n = n + sample_strobe;
      end
      check("strobe count", 24 / (d + 1), n[15:0]);
    end
    wr(13'h00b, 8'h00);
    for (i = 0; i < 11; i = i + 1) begin
      wr(13'h00d, codes[i]);
      check("test word", {4'h0, words[i]}, {4'h0, data_out});
    end
    wr(13'h00d, 8'h0d);
    check("unused test code", 16'h0000, {4'h0, data_out});
    for (i = 0; i < 2; i = i + 1) begin
      wr(13'h00d, i ? 8'h05 : 8'h06);
      w0 = data_out;
      @(posedge mclk);
      #2 w1 = data_out;
      if (i)
        check("long sequence shift", {5'h0, w0[10:0]}, {5'h0, w1[11:1]});
      else
        check("short sequence step", {7'h0, w0[7:0], w0[8] ^ w0[4]}, {4'h0, w1});
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr(13'h00d, i ? 8'h07 : 8'h04);
      w0 = data_out;
      @(posedge mclk);
      #2 w1 = data_out;
      check("alternating pair", 16'h0fff, {4'h0, w0 ^ w1});
      check("alternating word", 16'h0001,
            {15'h0, w0 === (i ? 12'hfff : 12'haaa) || w0 === (i ? 12'h000 : 12'h555)});
    end
    // Clock enable low must freeze the alternating output
    wr(13'h00d, 8'h04);
    ce = 1'b0;
    w0 = data_out;
    repeat (3) @(posedge mclk);
    #2 check("frozen output", {4'h0, w0}, {4'h0, data_out});
    ce = 1'b1;
    wr(13'h00d, 8'h00);
    wr(13'h00e, 8'h01);
    check("self test bits", 16'h0002, {14'h0, self_test_start, self_test_init});
    wr(13'h00e, 8'h04);
    check("self test bits", 16'h0001, {14'h0, self_test_start, self_test_init});
    wr(13'h010, 8'h81);
    check("offset trim", 16'h0081, {8'h00, offset_trim});
    i_acpc_host_model.access(1'b0, 2'b01, 13'h00e, 16'h0403, 16, q);
    rd_chk(13'h00e, 8'h04);
    rd_chk(13'h00d, 8'h03);
    tally_and_finish;
  end
endmodule // test_acpc_regs

bind acpc_regs acpc_regs_asserts #(.WIDTH(WIDTH)) i_acpc_regs_asserts (
  .mclk(mclk), .rst(rst), .data_out(data_out), .sample_strobe(sample_strobe),
  .power_down(power_down), .standby(standby), .digital_reset(digital_reset),
  .clk_div_ratio(clk_div_ratio), .offset_trim(offset_trim),
  .self_test_start(self_test_start), .self_test_init(self_test_init));
